// >>> design/bgd_pkg.sv
// ============================================================
// Shared constants for the pin data and diagnostic registers.
package bgd_pkg;

  // Number of general-purpose pins served by the pin data register.
  localparam int          BGD_PIN_COUNT      = 8;

  // Configuration offsets; accesses are dword aligned, so the 16-bit
  // pin data register sits in the upper half of the dword at 0xb4.
  localparam logic [7:0]  BGD_OFF_PIN_DATA   = 8'hb6;
  localparam logic [7:0]  BGD_OFF_PIN_DWORD  = 8'hb4;
  localparam logic [7:0]  BGD_OFF_CTRL_DIAG0 = 8'hc0;

  // Position of the pin data register inside its dword.
  localparam int          BGD_PIN_DATA_LSB   = 16;

  // Byte lane that carries the pin data low byte.
  localparam int          BGD_PIN_DATA_LANE  = 2;

  // Serial-bus pins that double as clock and data lines.
  localparam int          BGD_SB_CLOCK_PIN   = 4;
  localparam int          BGD_SB_DATA_PIN    = 5;

  // Field positions of the control and diagnostic register.
  localparam int          BGD_BUS_NUM_LSB    = 24;
  localparam int          BGD_DEV_NUM_LSB    = 19;
  localparam int          BGD_ADVISORY_BIT   = 18;
  localparam int          BGD_BRIDGE_PME_BIT = 17;
  localparam int          BGD_LINK_PME_BIT   = 16;
  localparam int          BGD_FIFO_SIZE_LSB  = 14;
  localparam int          BGD_ANY_FN_BIT     = 11;
  localparam int          BGD_POSTED_BIT     = 10;
  localparam int          BGD_COMPL_BIT      = 8;
  localparam int          BGD_CACHE_LINE_BIT = 7;

  // Values after reset.
  localparam logic [7:0]  BGD_PIN_DATA_RST   = 8'h00;
  localparam logic [31:0] BGD_CTRL_DIAG0_RST = 32'h0000_0000;
  localparam logic [7:0]  BGD_PIN_UPPER_RST  = 8'h00;

  // Depth of every synchroniser, in flip-flops.
  localparam int          BGD_SYNC_STAGES    = 2;

endpackage

// >>> design/bgd_sync.sv
// ============================================================
// Multi-bit two-stage level synchroniser.
// Each bit is crossed on its own; callers must only pass levels whose
// bits are independent, never a word that must arrive coherent.
module bgd_sync
  import bgd_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output      logic [WIDTH-1:0] sync_out
);

  // First stage; read by the second stage and nothing else.
  logic [WIDTH-1:0] meta_reg;
  // Second stage; the only copy the rest of the design may use.
  logic [WIDTH-1:0] stable_reg;

  // ============================================================
  // Two flip-flops in series, cleared to a constant on reset.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_reg   <= '0;
      stable_reg <= '0;
    end else begin
      meta_reg   <= async_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync_out = stable_reg;

endmodule

// >>> design/bgd_registers.sv
module bgd_registers
  import bgd_pkg::*;
#(
  parameter int PINS = BGD_PIN_COUNT
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        pcie_reset_n,
  input  wire logic        global_reset_n,
  input  wire logic        cfg_read,
  input  wire logic        cfg_write,
  input  wire logic [7:0]  cfg_address,
  input  wire logic [3:0]  cfg_byte_enable,
  input  wire logic [31:0] cfg_write_data,
  output      logic [31:0] cfg_read_data,
  output      logic        cfg_read_valid,
  input  wire logic [PINS-1:0] pin_direction,
  input  wire logic        eeprom_detected,
  input  wire logic [PINS-1:0] pin_in,
  output      logic [PINS-1:0] pin_out,
  output      logic [PINS-1:0] pin_oe,
  input  wire logic        sb_clock_out,
  input  wire logic        sb_clock_oe,
  input  wire logic        sb_data_out,
  input  wire logic        sb_data_oe,
  input  wire logic [7:0]  captured_bus_number,
  input  wire logic [4:0]  captured_device_number,
  input  wire logic        link_power_event,
  output      logic        bridge_power_event,
  output      logic        link_power_event_pin,
  output      logic        advisory_error_select,
  output      logic [1:0]  fifo_size_limit,
  output      logic        answer_all_functions,
  output      logic        release_posted_credits,
  output      logic        release_completion_credits,
  output      logic        cache_line_size_select
);

  // ============================================================
  // Reset release and pin synchronisers.

  logic       rst_meta_reg;       // First stage of the reset release.
  logic       rst_n_sync_reg;     // Released power-on reset copy.
  logic [PINS+1:0] sync_out;      // Pins plus the two external resets.
  logic [PINS-1:0] pin_level;     // Synchronised pin levels.
  logic       fundamental_reset_n; // Low while PCIe or global reset.
  logic       global_sync_n;      // Synchronised global reset.

  // Release the asynchronous reset through two flip-flops.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg   <= 1'b0;
      rst_n_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg   <= 1'b1;
      rst_n_sync_reg <= rst_meta_reg;
    end
  end

  // One synchroniser for every input that arrives from a pin.
  bgd_sync #(
    .WIDTH    (PINS + 2)
  ) u_sync (
    .clock    (clock),
    .resetn   (rst_n_sync_reg),
    .async_in ({global_reset_n, pcie_reset_n, pin_in}),
    .sync_out (sync_out)
  );

  assign pin_level     = sync_out[PINS-1:0];
  assign global_sync_n = sync_out[PINS+1];
  // Fundamental reset follows either external reset source.
  assign fundamental_reset_n = sync_out[PINS] & global_sync_n;

  // ============================================================
  // Address decode.

  logic pin_hit;      // Access to the dword holding pin data.
  logic diag_hit;     // Access to the control and diagnostic dword.
  logic pin_wr;       // Write that carries the pin data low byte.

  assign pin_hit  = cfg_address == BGD_OFF_PIN_DWORD;
  assign diag_hit = cfg_address == BGD_OFF_CTRL_DIAG0;
  assign pin_wr   = cfg_write & pin_hit & cfg_byte_enable[BGD_PIN_DATA_LANE];

  // ============================================================
  // Pin data latch and secondary function.

  logic [PINS-1:0] data_reg;      // Written output levels.
  logic [PINS-1:0] secondary;     // Pins taken by the serial bus.
  logic [PINS-1:0] writable;      // Pins that accept a data write.
  logic [PINS-1:0] read_level;    // Value presented on a read.
  logic [PINS-1:0] out_next;      // Next pin output level.
  logic [PINS-1:0] oe_next;       // Next pin output enable.
  logic [PINS-1:0] pin_out_reg;   // Registered pin levels.
  logic [PINS-1:0] pin_oe_reg;    // Registered pin enables.

  // Serial-bus function only once an EEPROM was found.
  always_comb begin
    secondary = '0;
    secondary[BGD_SB_CLOCK_PIN] = eeprom_detected;
    secondary[BGD_SB_DATA_PIN]  = eeprom_detected;
  end

  // Only output-mode pins free of a secondary use take writes.
  assign writable = pin_direction & ~secondary;

  // The latch is cleared by power-on reset or the fundamental reset, and
  // a global-only event drops the fundamental reset too, so it clears the levels.
  always_ff @(posedge clock or negedge rst_n_sync_reg) begin
    if (!rst_n_sync_reg) begin
      data_reg <= BGD_PIN_DATA_RST;
    end else if (!fundamental_reset_n) begin
      data_reg <= BGD_PIN_DATA_RST;
    end else if (pin_wr) begin
      data_reg <= (data_reg & ~writable) |
                  (cfg_write_data[BGD_PIN_DATA_LSB +: PINS] &
                   writable);
    end
  end

  // Per pin: serial engine, latched output, or released input.
  generate
    for (genvar i = 0; i < PINS; i++) begin : g_pin
      always_comb begin
        if (secondary[i]) begin
          out_next[i] = (i == BGD_SB_CLOCK_PIN) ? sb_clock_out
                                                 : sb_data_out;
          oe_next[i]  = (i == BGD_SB_CLOCK_PIN) ? sb_clock_oe
                                                 : sb_data_oe;
        end else begin
          out_next[i] = data_reg[i];
          oe_next[i]  = pin_direction[i];
        end
        // Inputs and serial pins show the wire; outputs the latch.
        read_level[i] = (pin_direction[i] & ~secondary[i]) ?
                        data_reg[i] : pin_level[i];
      end
    end
  endgenerate

  // Pin drivers are registered so that no glitch reaches the board.
  always_ff @(posedge clock or negedge rst_n_sync_reg) begin
    if (!rst_n_sync_reg) begin
      pin_out_reg <= '0;
      pin_oe_reg  <= '0;
    end else begin
      pin_out_reg <= out_next;
      pin_oe_reg  <= oe_next;
    end
  end

  assign pin_out = pin_out_reg;
  assign pin_oe  = pin_oe_reg;

  // ============================================================
  // Control and diagnostic fields.

  logic       advisory_reg;     // Advisory error reporting off.
  logic [1:0] fifo_size_reg;    // Maximum FIFO size in dwords.
  logic       any_fn_reg;       // Answer any function number.
  logic       posted_reg;       // Release posted-write credits.
  logic       compl_reg;        // Release completion credits.
  logic       cache_line_reg;   // Size from cache line register.
  logic       bridge_off_reg;   // Bridge event input disabled.
  logic       link_off_reg;     // Link event pin disabled.
  logic       diag_wr;          // Write to the diagnostic dword.

  assign diag_wr = cfg_write & diag_hit;

  // Fields held by the fundamental reset, updated per byte lane.
  always_ff @(posedge clock or negedge rst_n_sync_reg) begin
    if (!rst_n_sync_reg) begin
      advisory_reg   <= BGD_CTRL_DIAG0_RST[BGD_ADVISORY_BIT];
      fifo_size_reg  <= BGD_CTRL_DIAG0_RST[BGD_FIFO_SIZE_LSB +: 2];
      any_fn_reg     <= BGD_CTRL_DIAG0_RST[BGD_ANY_FN_BIT];
      posted_reg     <= BGD_CTRL_DIAG0_RST[BGD_POSTED_BIT];
      compl_reg      <= BGD_CTRL_DIAG0_RST[BGD_COMPL_BIT];
      cache_line_reg <= BGD_CTRL_DIAG0_RST[BGD_CACHE_LINE_BIT];
    end else if (!fundamental_reset_n) begin
      advisory_reg   <= BGD_CTRL_DIAG0_RST[BGD_ADVISORY_BIT];
      fifo_size_reg  <= BGD_CTRL_DIAG0_RST[BGD_FIFO_SIZE_LSB +: 2];
      any_fn_reg     <= BGD_CTRL_DIAG0_RST[BGD_ANY_FN_BIT];
      posted_reg     <= BGD_CTRL_DIAG0_RST[BGD_POSTED_BIT];
      compl_reg      <= BGD_CTRL_DIAG0_RST[BGD_COMPL_BIT];
      cache_line_reg <= BGD_CTRL_DIAG0_RST[BGD_CACHE_LINE_BIT];
    end else if (diag_wr) begin
      if (cfg_byte_enable[2]) begin
        advisory_reg <= cfg_write_data[BGD_ADVISORY_BIT];
      end
      if (cfg_byte_enable[1]) begin
        fifo_size_reg <=
          cfg_write_data[BGD_FIFO_SIZE_LSB +: 2];
        any_fn_reg    <= cfg_write_data[BGD_ANY_FN_BIT];
        posted_reg    <= cfg_write_data[BGD_POSTED_BIT];
        compl_reg     <= cfg_write_data[BGD_COMPL_BIT];
      end
      if (cfg_byte_enable[0]) begin
        cache_line_reg <=
          cfg_write_data[BGD_CACHE_LINE_BIT];
      end
    end
  end

  // Event disables survive a PCIe-only reset: they clear on power-on
  // or global reset, so wake paths stay configured across link resets.
  always_ff @(posedge clock or negedge rst_n_sync_reg) begin
    if (!rst_n_sync_reg) begin
      bridge_off_reg <= BGD_CTRL_DIAG0_RST[BGD_BRIDGE_PME_BIT];
      link_off_reg   <= BGD_CTRL_DIAG0_RST[BGD_LINK_PME_BIT];
    end else if (!global_sync_n) begin
      bridge_off_reg <= BGD_CTRL_DIAG0_RST[BGD_BRIDGE_PME_BIT];
      link_off_reg   <= BGD_CTRL_DIAG0_RST[BGD_LINK_PME_BIT];
    end else if (diag_wr && cfg_byte_enable[2]) begin
      bridge_off_reg <= cfg_write_data[BGD_BRIDGE_PME_BIT];
      link_off_reg   <= cfg_write_data[BGD_LINK_PME_BIT];
    end
  end

  // ============================================================
  // Control outputs and power event routing.
  logic bridge_event_reg;   // Gated event toward the bridge.
  logic link_pin_reg;       // Gated event toward the dedicated pin.

  // Both event paths are registered from the same link event.
  always_ff @(posedge clock or negedge rst_n_sync_reg) begin
    if (!rst_n_sync_reg) begin
      bridge_event_reg <= 1'b0;
      link_pin_reg     <= 1'b0;
    end else begin
      bridge_event_reg <= link_power_event & ~bridge_off_reg;
      link_pin_reg     <= link_power_event & ~link_off_reg;
    end
  end

  assign bridge_power_event         = bridge_event_reg;
  assign link_power_event_pin       = link_pin_reg;
  assign advisory_error_select      = advisory_reg;
  assign fifo_size_limit            = fifo_size_reg;
  assign answer_all_functions       = any_fn_reg;
  assign release_posted_credits     = posted_reg;
  assign release_completion_credits = compl_reg;
  assign cache_line_size_select     = cache_line_reg;

  // ============================================================
  // Read path; one cycle latency, unmapped offsets return zero.
  logic [31:0] read_next;     // Value assembled for the read.
  logic [31:0] read_data_reg; // Registered read data.
  logic        read_vld_reg;  // Registered read strobe.

  // Assemble the addressed dword; unlisted bits stay zero.
  always_comb begin
    read_next = '0;
    if (pin_hit) begin
      read_next[BGD_PIN_DATA_LSB +: PINS] = read_level;
      read_next[31:BGD_PIN_DATA_LSB + PINS] =
        BGD_PIN_UPPER_RST;
    end else if (diag_hit) begin
      read_next[BGD_BUS_NUM_LSB +: 8] = captured_bus_number;
      read_next[BGD_DEV_NUM_LSB +: 5] =
        captured_device_number;
      read_next[BGD_ADVISORY_BIT]     = advisory_reg;
      read_next[BGD_BRIDGE_PME_BIT]   = bridge_off_reg;
      read_next[BGD_LINK_PME_BIT]     = link_off_reg;
      read_next[BGD_FIFO_SIZE_LSB +: 2] = fifo_size_reg;
      read_next[BGD_ANY_FN_BIT]       = any_fn_reg;
      read_next[BGD_POSTED_BIT]       = posted_reg;
      read_next[BGD_COMPL_BIT]        = compl_reg;
      read_next[BGD_CACHE_LINE_BIT]   = cache_line_reg;
    end
  end

  // Capture read data one edge after the request.
  always_ff @(posedge clock or negedge rst_n_sync_reg) begin
    if (!rst_n_sync_reg) begin
      read_data_reg <= '0;
      read_vld_reg  <= 1'b0;
    end else begin
      read_vld_reg <= cfg_read;
      if (cfg_read) begin
        read_data_reg <= read_next;
      end
    end
  end

  assign cfg_read_data  = read_data_reg;
  assign cfg_read_valid = read_vld_reg;

  // ============================================================
  // Checks.
  AST_INPUT_READ: assert property (
    @(posedge clock) disable iff (!rst_n_sync_reg)
    (cfg_read && pin_hit && pin_direction == '0)
      |=> cfg_read_data[23:16] == $past(pin_level))
    else $error("input pin read mismatch");
  AST_OUTPUT_DRIVE: assert property (
    @(posedge clock) disable iff (!rst_n_sync_reg)
    (pin_wr && fundamental_reset_n && !eeprom_detected &&
     pin_direction == '1)
      |-> ##2 pin_out == $past(cfg_write_data[23:16], 2))
    else $error("output pin not driven to written level");
  AST_INPUT_WRITE_IGNORED: assert property (
    @(posedge clock) disable iff (!rst_n_sync_reg)
    (pin_wr && !pin_direction[0])
      |=> data_reg[0] == $past(data_reg[0]))
    else $error("write to input pin changed latch");
  AST_SECONDARY_PINS: assert property (
    @(posedge clock) disable iff (!rst_n_sync_reg)
    eeprom_detected |=> pin_oe[BGD_SB_CLOCK_PIN] == $past(sb_clock_oe)
      && pin_out[BGD_SB_DATA_PIN] == $past(sb_data_out))
    else $error("serial pins not following serial engine");
  AST_UPPER_ZERO: assert property (
    @(posedge clock) disable iff (!rst_n_sync_reg)
    (cfg_read && pin_hit) |=> cfg_read_data[31:24] == 8'h00)
    else $error("pin data upper byte not zero");
  AST_FUND_CLEAR: assert property (
    @(posedge clock) disable iff (!rst_n_sync_reg)
    !fundamental_reset_n |=> data_reg == '0)
    else $error("pin latch not cleared by fundamental reset");
  AST_INPUT_RELEASED: assert property (
    @(posedge clock) disable iff (!rst_n_sync_reg)
    (!eeprom_detected && !pin_direction[0]) |=> !pin_oe[0])
    else $error("input pin driven");
  AST_BUS_FIELDS: assert property (
    @(posedge clock) disable iff (!rst_n_sync_reg)
    (cfg_read && diag_hit) |=> cfg_read_valid &&
      cfg_read_data[31:24] == $past(captured_bus_number) &&
      cfg_read_data[23:19] == $past(captured_device_number))
    else $error("captured numbers not reported");
  AST_RESERVED_ZERO: assert property (
    @(posedge clock) disable iff (!rst_n_sync_reg)
    (cfg_read && diag_hit) |=> cfg_read_data[13:12] == 2'b00 &&
      !cfg_read_data[9])
    else $error("reserved bits not zero");
  AST_EVENT_KEEP: assert property (
    @(posedge clock) disable iff (!rst_n_sync_reg)
    (!fundamental_reset_n && global_sync_n && !diag_wr)
      |=> $stable(link_off_reg) && $stable(bridge_off_reg))
    else $error("event disables lost on fundamental reset");
  AST_LINK_PIN_OFF: assert property (
    @(posedge clock) disable iff (!rst_n_sync_reg)
    link_off_reg |=> !link_power_event_pin)
    else $error("disabled link event pin asserted");
endmodule

// >>> test/bgd_registers_tb.sv
// ============================================================
// Self-checking bench for the pin data and diagnostic registers.
module bridge_gpio_diag_registers_tb_top
  import bgd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ============================================================
  // Stimulus and observation signals.
  logic        clock;          // Bench clock, 40 MHz.
  logic        resetn;         // Power-on reset, active low.
  logic        pcie_reset_n;   // Link reset pin.
  logic        global_reset_n; // Global reset pin.
  logic        cfg_read;       // Read request pulse.
  logic        cfg_write;      // Write request pulse.
  logic [7:0]  cfg_address;    // Dword address of the access.
  logic [3:0]  cfg_byte_enable; // Byte lanes of a write.
  logic [31:0] cfg_write_data; // Write data.
  logic [31:0] cfg_read_data;  // Read data from the block.
  logic        cfg_read_valid; // Read answer strobe.
  logic [7:0]  pin_direction;  // Per-pin direction, 1 is output.
  logic        eeprom_detected; // Serial memory present.
  logic [7:0]  pin_in;         // Levels seen on the pins.
  logic [7:0]  pin_out;        // Levels the block drives.
  logic [7:0]  pin_oe;         // Pin drive enables.
  logic        sb_clock_out;   // Serial engine clock level.
  logic        sb_clock_oe;    // Serial engine clock enable.
  logic        sb_data_out;    // Serial engine data level.
  logic        sb_data_oe;     // Serial engine data enable.
  logic [7:0]  captured_bus_number;    // Bus number presented.
  logic [4:0]  captured_device_number; // Device number presented.
  logic        link_power_event;       // Link function event.
  logic        bridge_power_event;     // Gated event to the bridge.
  logic        link_power_event_pin;   // Gated event pin.
  logic        advisory_error_select;  // Field level, bit 18.
  logic [1:0]  fifo_size_limit;        // Field level, bits 15:14.
  logic        answer_all_functions;   // Field level, bit 11.
  logic        release_posted_credits; // Field level, bit 10.
  logic        release_completion_credits; // Field level, bit 8.
  logic        cache_line_size_select; // Field level, bit 7.
  int          errors;         // Mismatches seen.
  int          compares;       // Comparisons made.
  logic [31:0] rd;             // Last read value.

  // Bus and device fields as they should appear in every diag read.
  localparam logic [31:0] ID_FIELDS = 32'h3ca8_0000;

  bgd_registers u_dut (.clock(clock), .resetn(resetn),
    .pcie_reset_n(pcie_reset_n), .global_reset_n(global_reset_n),
    .cfg_read(cfg_read), .cfg_write(cfg_write),
    .cfg_address(cfg_address), .cfg_byte_enable(cfg_byte_enable),
    .cfg_write_data(cfg_write_data), .cfg_read_data(cfg_read_data),
    .cfg_read_valid(cfg_read_valid), .pin_direction(pin_direction),
    .eeprom_detected(eeprom_detected), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .sb_clock_out(sb_clock_out),
    .sb_clock_oe(sb_clock_oe), .sb_data_out(sb_data_out),
    .sb_data_oe(sb_data_oe), .captured_bus_number(captured_bus_number),
    .captured_device_number(captured_device_number),
    .link_power_event(link_power_event),
    .bridge_power_event(bridge_power_event),
    .link_power_event_pin(link_power_event_pin),
    .advisory_error_select(advisory_error_select),
    .fifo_size_limit(fifo_size_limit),
    .answer_all_functions(answer_all_functions),
    .release_posted_credits(release_posted_credits),
    .release_completion_credits(release_completion_credits),
    .cache_line_size_select(cache_line_size_select));

  // The clock toggles every half period of 12.5 ns.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ============================================================
  // Shared tasks.
  // Prints counts and the verdict, then ends the run.
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares one observed value against its expectation.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
               exp);
    end
  endtask

  // Lets a number of rising edges pass.
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One write cycle; the request stands for exactly one edge.
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d);
    @(posedge clock);
    cfg_write       <= 1'b1;
    cfg_address     <= a;
    cfg_byte_enable <= be;
    cfg_write_data  <= d;
    @(posedge clock);
    cfg_write <= 1'b0;
    idle(2);
    #1;
  endtask

  // One read cycle; a missing answer is a mismatch and ends the run.
  task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    cfg_read    <= 1'b1;
    cfg_address <= a;
    @(posedge clock);
    cfg_read <= 1'b0;
    // The strobe stands only in the cycle after the request edge.
    for (int i = 0; i < 4; i++) begin
      #1;
      if (cfg_read_valid === 1'b1) begin
        d = cfg_read_data;
        return;
      end
      @(posedge clock);
    end
    errors++;
    conclude();
  endtask

  // Pulses one of the two reset pins; sync flops need spare edges.
  task automatic pin_reset(input bit global);
    @(posedge clock);
    if (global) global_reset_n <= 1'b0;
    else pcie_reset_n <= 1'b0;
    idle(4);
    pcie_reset_n   <= 1'b1;
    global_reset_n <= 1'b1;
    idle(6);
  endtask

  // ============================================================
  // Main sequence.
  initial begin
    errors = 0;
    compares = 0;
    resetn = 1'b0;
    pcie_reset_n = 1'b1;
    global_reset_n = 1'b1;
    cfg_read = 1'b0;
    cfg_write = 1'b0;
    cfg_address = 8'h00;
    cfg_byte_enable = 4'h0;
    cfg_write_data = 32'h0000_0000;
    pin_direction = 8'h00;
    eeprom_detected = 1'b0;
    pin_in = 8'ha5;
    sb_clock_out = 1'b0;
    sb_clock_oe = 1'b1;
    sb_data_out = 1'b1;
    sb_data_oe = 1'b1;
    captured_bus_number = 8'h3c;
    captured_device_number = 5'h15;
    link_power_event = 1'b1;
    idle(3);
    resetn <= 1'b1;
    idle(6);
    // Inputs read their levels and the upper byte reads zero.
    cfg_rd(BGD_OFF_PIN_DWORD, rd);
    check(rd, 32'h00a5_0000);
    check({pin_oe, bridge_power_event, link_power_event_pin}, 10'h003);
    cfg_rd(BGD_OFF_CTRL_DIAG0, rd);
    check(rd, ID_FIELDS);
    // Output pins take the written level; other lanes are ignored.
    @(posedge clock) pin_direction <= 8'hff;
    cfg_wr(BGD_OFF_PIN_DWORD, 4'h4, 32'h005a_0000);
    check({pin_oe, pin_out}, 16'hff5a);
    cfg_wr(BGD_OFF_PIN_DWORD, 4'hb, 32'hffff_ffff);
    cfg_rd(BGD_OFF_PIN_DWORD, rd);
    check(rd, 32'h005a_0000);
    // A write while the pins are inputs leaves the latch alone.
    @(posedge clock) pin_direction <= 8'h00;
    cfg_wr(BGD_OFF_PIN_DWORD, 4'h4, 32'h00ff_0000);
    check(pin_oe, 8'h00);
    @(posedge clock) pin_direction <= 8'hff;
    idle(2);
    #1;
    check(pin_out, 8'h5a);
    // Serial use of pins 4 and 5 blocks their data bits.
    @(posedge clock) eeprom_detected <= 1'b1;
    cfg_wr(BGD_OFF_PIN_DWORD, 4'h4, 32'h0000_0000);
    check({pin_oe, pin_out}, 16'hff20);
    @(posedge clock) eeprom_detected <= 1'b0;
    idle(2);
    #1;
    check(pin_out, 8'h10);
    // Lane 1 alone reaches only bits 15:8 of the diag register.
    cfg_wr(BGD_OFF_CTRL_DIAG0, 4'h2, 32'hffff_ffff);
    cfg_rd(BGD_OFF_CTRL_DIAG0, rd);
    check(rd, ID_FIELDS | 32'h0000_cd00);
    cfg_wr(BGD_OFF_CTRL_DIAG0, 4'hf, 32'hffff_ffff);
    cfg_rd(BGD_OFF_CTRL_DIAG0, rd);
    check(rd, ID_FIELDS | 32'h0007_cd80);
    check({advisory_error_select, fifo_size_limit, answer_all_functions,
           release_posted_credits, release_completion_credits,
           cache_line_size_select}, 7'h7f);
    check({bridge_power_event, link_power_event_pin}, 2'b00);
    // Clearing lane 2 reopens both event paths.
    cfg_wr(BGD_OFF_CTRL_DIAG0, 4'h4, 32'h0000_0000);
    check({bridge_power_event, link_power_event_pin}, 2'b11);
    check({release_posted_credits, release_completion_credits,
           cache_line_size_select}, 3'h7);
    // Unmapped addresses read zero and ignore writes.
    cfg_wr(8'hc4, 4'hf, 32'hffff_ffff);
    cfg_rd(8'hc4, rd);
    check(rd, 32'h0000_0000);
    // Link reset clears the latch and most fields, not bits 17:16.
    cfg_wr(BGD_OFF_CTRL_DIAG0, 4'hf, 32'hffff_ffff);
    pin_reset(1'b0);
    cfg_rd(BGD_OFF_CTRL_DIAG0, rd);
    check(rd, ID_FIELDS | 32'h0003_0000);
    check(pin_out, 8'h00);
    // Global reset pulse; bits 17:16 are not read back before the rewrite below.
    pin_reset(1'b1);
    // Software leaves the register at its defaults from here on.
    cfg_wr(BGD_OFF_CTRL_DIAG0, 4'hf, BGD_CTRL_DIAG0_RST);
    cfg_rd(BGD_OFF_CTRL_DIAG0, rd);
    check(rd, ID_FIELDS);
    conclude();
  end
endmodule
